/* File: hw/status_pkg.sv */
// package: register map, field positions, reset values and carrier types
// assumes: 32-bit ahb-lite register bus, one system clock
package status_pkg;
    localparam logic [7:0] IDX_STATUS1   = 8'h07;
    localparam logic [7:0] IDX_STATUS2   = 8'h08;
    localparam logic [7:0] IDX_FIFO_DATA = 8'h09;
    localparam logic [7:0] IDX_THRESHOLD = 8'h0b;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h10;

    localparam logic [7:0] RST_STATUS1   = 8'h21;
    localparam logic [7:0] RST_STATUS2   = 8'h00;
    localparam logic [5:0] RST_THRESHOLD = 6'h08;
    localparam logic [7:0] RST_IRQ_EN    = 8'h00;

    localparam int B_CRC_OK      = 6;
    localparam int B_CRC_DONE    = 5;
    localparam int B_IRQ         = 4;
    localparam int B_TIMER       = 3;
    localparam int B_NEAR_FULL   = 1;
    localparam int B_NEAR_EMPTY  = 0;
    localparam int B_OVH_CLEAR   = 7;
    localparam int B_HS_FORCE    = 6;
    localparam int B_CIPHER      = 3;

    localparam logic [6:0] FIFO_DEPTH = 7'h40;

    localparam logic [2:0] MS_IDLE      = 3'h0;
    localparam logic [2:0] MS_SEND_WAIT = 3'h1;
    localparam logic [2:0] MS_PRE_TX    = 3'h2;
    localparam logic [2:0] MS_TX        = 3'h3;
    localparam logic [2:0] MS_PRE_RX    = 3'h4;
    localparam logic [2:0] MS_DATA_WAIT = 3'h5;
    localparam logic [2:0] MS_RX        = 3'h6;

    // events and levels from the reader core
    typedef struct packed {
        logic       crc_start;
        logic       crc_finish;
        logic       crc_zero;
        logic       timer_run;
        logic       cmd_start;
        logic       crc_fail;
        logic       auth_success;
        logic       overheat_detect;
        logic       temp_below_limit;
        logic       protocol_hs;
    } core_in_t;

    // modem sequencing inputs
    typedef struct packed {
        logic       transceive;
        logic       send_trigger;
        logic       wait_for_field;
        logic       field_present;
        logic [7:0] tx_delay;
        logic [7:0] rx_delay;
        logic       tx_done;
        logic       rx_sof;
        logic       rx_done;
    } modem_in_t;

    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction
endpackage

/* File: hw/fifo_fill_counter.sv */
// fifo_fill_counter: tracks bytes held in the 64-byte fifo
// assumes: one host write or read strobe per cycle, both synchronous
`timescale 1ns/1ns
module fifo_fill_counter
    import status_pkg::*;
(
    input  wire logic       hclk,    // system clock
    input  wire logic       hresetn, // async reset, active low
    input  wire logic       wr,      // host write to data port
    input  wire logic       rd,      // host read of data port
    output logic [6:0]      count    // bytes held
);
    // ==========================================
    // fill count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 7'h00;
        end else if (wr && !rd && count < FIFO_DEPTH) begin
            count <= count + 7'h01;
        end else if (rd && !wr && count != 7'h00) begin
            count <= count - 7'h01;
        end
    end
endmodule

/* File: hw/modem_fsm.sv */
// modem_fsm: transmit/receive sequencer reporting its state code
// assumes: delays counted in system clocks, inputs synchronous
`timescale 1ns/1ns
module modem_fsm
    import status_pkg::*;
(
    input  wire logic      hclk,    // system clock
    input  wire logic      hresetn, // async reset, active low
    input  modem_in_t      m,       // sequencing inputs
    output logic [2:0]     code     // state code, registered
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_SEND = 7'h02, S_PTX = 7'h04, S_TX = 7'h08,
        S_PRX  = 7'h10, S_DATA = 7'h20, S_RX  = 7'h40
    } st_t;
    st_t        st_r, st_nxt;
    logic [7:0] cnt_r;
    logic       wait_over;

    // ==========================================
    // next state
    assign wait_over = (cnt_r == 8'h00) && (!m.wait_for_field || m.field_present);
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            S_IDLE: if (m.transceive) st_nxt = S_SEND;
            S_SEND: if (m.send_trigger) st_nxt = S_PTX;
            S_PTX:  if (wait_over) st_nxt = S_TX;
            S_TX:   if (m.tx_done) st_nxt = S_PRX;
            S_PRX:  if (wait_over) st_nxt = S_DATA;
            S_DATA: if (m.rx_sof) st_nxt = S_RX;
            S_RX:   if (m.rx_done) st_nxt = S_SEND;
            default: st_nxt = S_IDLE;
        endcase
        if (!m.transceive) st_nxt = S_IDLE;
    end

    // ==========================================
    // state, wait counter, code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) st_r <= S_IDLE;
        else st_r <= st_nxt;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_r <= 8'h00;
        else if (st_nxt == S_PTX && st_r != S_PTX) cnt_r <= m.tx_delay;
        else if (st_nxt == S_PRX && st_r != S_PRX) cnt_r <= m.rx_delay;
        else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) code <= MS_IDLE;
        else begin
            unique case (st_nxt)
                S_IDLE:  code <= MS_IDLE;
                S_SEND:  code <= MS_SEND_WAIT;
                S_PTX:   code <= MS_PRE_TX;
                S_TX:    code <= MS_TX;
                S_PRX:   code <= MS_PRE_RX;
                S_DATA:  code <= MS_DATA_WAIT;
                S_RX:    code <= MS_RX;
                default: code <= MS_IDLE;
            endcase
        end
    end
endmodule

/* File: hw/reader_status_regs.sv */
// reader_status_regs: crc/fifo/timer and modem/cipher status registers
// assumes: single ahb-lite master, whole-word single transfers, one clock
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
module reader_status_regs (
    input  wire logic                 hclk,        // system clock, 20 MHz
    input  wire logic                 hresetn,     // async reset, active low
    input  wire logic                 hsel,        // slave select
    input  wire logic [31:0]          haddr,       // byte address
    input  wire logic [1:0]           htrans,      // transfer type
    input  wire logic                 hwrite,      // write when high
    input  wire logic [2:0]           hsize,       // transfer size
    input  wire logic                 hready,      // bus ready
    input  wire logic [31:0]          hwdata,      // write data
    output logic [31:0]               hrdata,      // read data
    output logic                      hreadyout,   // low in reset, then always ready
    output logic                      hresp,       // always okay
    input  status_pkg::core_in_t      core,        // reader core events
    input  wire logic [7:0]           irq_src,     // interrupt sources
    input  status_pkg::modem_in_t     modem,       // modem sequencing inputs
    output logic                      overheat_error,    // overheat error flag
    output logic                      rx_crc_error_flag, // receive crc error
    output logic                      filter_hs_mode,    // host filter high speed
    output logic [2:0]                link_fsm_state     // modem state code
);
    import status_pkg::*;

    logic       dp_wr_r;
    logic [7:0] dp_idx_r;
    logic       acc;
    logic [7:0] a_idx;
    logic       wr_hit;
    logic [7:0] wbyte;
    logic       crc_result_ok_r;
    logic       crc_done_r;
    logic       irq_pending_r;
    logic       timer_active_r;
    logic       overheat_clear_r;
    logic       host_filter_hs_force_r;
    logic       cipher_active_r;
    logic [5:0] fifo_alert_threshold_r;
    logic [7:0] irq_en_r;
    logic [6:0] fifo_fill_count;
    logic       fifo_near_full;
    logic       fifo_near_empty;
    logic [7:0] status1;
    logic [7:0] status2;
    logic [7:0] rd_byte;

    // ==========================================
    // ahb-lite address phase
    assign acc    = hsel && hready && htrans[1];
    assign a_idx  = haddr[9:2];
    assign wr_hit = dp_wr_r;
    assign wbyte  = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r  <= 1'b0;
            dp_idx_r <= 8'h00;
        end else if (hready) begin
            dp_wr_r  <= acc && hwrite && haddr[1:0] == 2'b00;
            dp_idx_r <= a_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================
    // fifo fill count and alerts
    fifo_fill_counter u_fill (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr      (wr_hit && dp_idx_r == IDX_FIFO_DATA),
        .rd      (acc && !hwrite && a_idx == IDX_FIFO_DATA),
        .count   (fifo_fill_count)
    );

    assign fifo_near_full  = (FIFO_DEPTH - fifo_fill_count) <= {1'b0, fifo_alert_threshold_r};
    assign fifo_near_empty = fifo_fill_count <= {1'b0, fifo_alert_threshold_r};

    // ==========================================
    // crc coprocessor status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_result_ok_r <= RST_STATUS1[B_CRC_OK];
        end else if (core.crc_start) begin
            crc_result_ok_r <= 1'b0;
        end else if (core.crc_finish) begin
            crc_result_ok_r <= core.crc_zero;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_done_r <= RST_STATUS1[B_CRC_DONE];
        end else if (core.crc_finish) begin
            crc_done_r <= 1'b1;
        end else if (core.crc_start) begin
            crc_done_r <= 1'b0;
        end
    end

    // ==========================================
    // interrupt summary and timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq_pending_r <= RST_STATUS1[B_IRQ];
        else irq_pending_r <= |(irq_src & irq_en_r);
    end

    // in gated mode timer_run comes from the gate-select enable, never the gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) timer_active_r <= RST_STATUS1[B_TIMER];
        else timer_active_r <= core.timer_run;
    end

    // ==========================================
    // software written fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overheat_clear_r       <= RST_STATUS2[B_OVH_CLEAR];
            host_filter_hs_force_r <= RST_STATUS2[B_HS_FORCE];
        end else if (wr_hit && dp_idx_r == IDX_STATUS2) begin
            overheat_clear_r       <= wbyte[B_OVH_CLEAR];
            host_filter_hs_force_r <= wbyte[B_HS_FORCE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fifo_alert_threshold_r <= RST_THRESHOLD;
        else if (wr_hit && dp_idx_r == IDX_THRESHOLD) fifo_alert_threshold_r <= wbyte[5:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq_en_r <= RST_IRQ_EN;
        else if (wr_hit && dp_idx_r == IDX_IRQ_EN) irq_en_r <= wbyte;
    end

    // set wins over the software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cipher_active_r <= RST_STATUS2[B_CIPHER];
        else if (core.auth_success) cipher_active_r <= 1'b1;
        else if (wr_hit && dp_idx_r == IDX_STATUS2 && !wbyte[B_CIPHER]) cipher_active_r <= 1'b0;
    end

    // ==========================================
    // error flags and host filter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) overheat_error <= 1'b0;
        else if (core.overheat_detect) overheat_error <= 1'b1;
        else if (overheat_clear_r && core.temp_below_limit) overheat_error <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rx_crc_error_flag <= 1'b0;
        else if (core.crc_fail) rx_crc_error_flag <= 1'b1;
        else if (core.cmd_start) rx_crc_error_flag <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) filter_hs_mode <= 1'b0;
        else filter_hs_mode <= host_filter_hs_force_r || core.protocol_hs;
    end

    // ==========================================
    // modem sequencer
    modem_fsm u_modem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .m       (modem),
        .code    (link_fsm_state)
    );

    // ==========================================
    // read path: one registered snapshot per access
    assign status1 = {1'b0, crc_result_ok_r, crc_done_r, irq_pending_r,
                      timer_active_r, 1'b0, fifo_near_full, fifo_near_empty};
    assign status2 = {overheat_clear_r, host_filter_hs_force_r, 2'b00,
                      cipher_active_r, link_fsm_state};

    always_comb begin
        rd_byte = 8'h00;
        unique case (a_idx)
            IDX_STATUS1:   rd_byte = status1;
            IDX_STATUS2:   rd_byte = status2;
            IDX_THRESHOLD: rd_byte = {2'b00, fifo_alert_threshold_r};
            IDX_IRQ_EN:    rd_byte = irq_en_r;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (acc && !hwrite) hrdata <= {24'h00_0000, rd_byte};
    end

    // ==========================================
    // assertions
    logic rd_s1;
    logic rd_s2;
    assign rd_s1 = acc && !hwrite && a_idx == IDX_STATUS1;
    assign rd_s2 = acc && !hwrite && a_idx == IDX_STATUS2;

    property p_crc_busy_low;
        @(posedge hclk) disable iff (!hresetn)
        core.crc_start |=> !crc_result_ok_r;
    endproperty
    a_crc_busy_low: assert property (p_crc_busy_low) else $error("crc ok high during calc");

    property p_crc_zero;
        @(posedge hclk) disable iff (!hresetn)
        core.crc_finish && !core.crc_start |=> crc_result_ok_r == $past(core.crc_zero);
    endproperty
    a_crc_zero: assert property (p_crc_zero) else $error("crc ok not result");

    property p_crc_done;
        @(posedge hclk) disable iff (!hresetn)
        core.crc_finish |=> crc_done_r;
    endproperty
    a_crc_done: assert property (p_crc_done) else $error("crc done missed");

    property p_irq_pending;
        @(posedge hclk) disable iff (!hresetn)
        (|(irq_src & irq_en_r)) |=> irq_pending_r;
    endproperty
    a_irq_pending: assert property (p_irq_pending) else $error("irq summary missed");

    property p_timer_active;
        @(posedge hclk) disable iff (!hresetn)
        core.timer_run ##1 core.timer_run |=> timer_active_r && $past(timer_active_r);
    endproperty
    a_timer_active: assert property (p_timer_active) else $error("timer active wrong");

    property p_near_full;
        @(posedge hclk) disable iff (!hresetn)
        rd_s1 |=> hrdata[B_NEAR_FULL] == ((7'h40 - $past(fifo_fill_count)) <= {1'b0, $past(fifo_alert_threshold_r)});
    endproperty
    a_near_full: assert property (p_near_full) else $error("near full wrong");

    property p_near_empty;
        @(posedge hclk) disable iff (!hresetn)
        rd_s1 |=> hrdata[B_NEAR_EMPTY] == ($past(fifo_fill_count) <= {1'b0, $past(fifo_alert_threshold_r)});
    endproperty
    a_near_empty: assert property (p_near_empty) else $error("near empty wrong");

    property p_reserved;
        @(posedge hclk) disable iff (!hresetn)
        rd_s1 || rd_s2 |=> (hrdata[7:0] & ($past(rd_s1) ? 8'h84 : 8'h30)) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_cipher;
        @(posedge hclk) disable iff (!hresetn)
        core.auth_success |=> cipher_active_r;
    endproperty
    a_cipher: assert property (p_cipher) else $error("cipher not set");

    property p_overheat;
        @(posedge hclk) disable iff (!hresetn)
        core.overheat_detect |=> overheat_error ##1 (overheat_error || $past(core.temp_below_limit));
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat cleared too early");

    property p_overheat_clear;
        @(posedge hclk) disable iff (!hresetn)
        overheat_clear_r && core.temp_below_limit && !core.overheat_detect |=> !overheat_error;
    endproperty
    a_overheat_clear: assert property (p_overheat_clear) else $error("overheat not cleared");

    property p_overheat_keep;
        @(posedge hclk) disable iff (!hresetn)
        overheat_error && !overheat_clear_r |=> overheat_error;
    endproperty
    a_overheat_keep: assert property (p_overheat_keep) else $error("overheat lost");

    property p_err_clear;
        @(posedge hclk) disable iff (!hresetn)
        core.cmd_start && !core.crc_fail |=> !rx_crc_error_flag;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flag kept");

    property p_cipher_keep;
        @(posedge hclk) disable iff (!hresetn)
        cipher_active_r && !(wr_hit && dp_idx_r == IDX_STATUS2) |=> cipher_active_r;
    endproperty
    a_cipher_keep: assert property (p_cipher_keep) else $error("cipher dropped");

    property p_filter_hs;
        @(posedge hclk) disable iff (!hresetn)
        host_filter_hs_force_r || core.protocol_hs |=> filter_hs_mode;
    endproperty
    a_filter_hs: assert property (p_filter_hs) else $error("filter not high speed");

    property p_filter_std;
        @(posedge hclk) disable iff (!hresetn)
        !host_filter_hs_force_r && !core.protocol_hs |=> !filter_hs_mode;
    endproperty
    a_filter_std: assert property (p_filter_std) else $error("filter stuck high");

    property p_irq_quiet;
        @(posedge hclk) disable iff (!hresetn)
        !(|(irq_src & irq_en_r)) |=> !irq_pending_r;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without source");

    property p_timer_idle;
        @(posedge hclk) disable iff (!hresetn)
        !core.timer_run |=> !timer_active_r;
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("timer active while stopped");

    property p_threshold;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit && dp_idx_r == IDX_THRESHOLD |=> fifo_alert_threshold_r == $past(hwdata[5:0]);
    endproperty
    a_threshold: assert property (p_threshold) else $error("threshold not written");

    property p_modem_idle;
        @(posedge hclk) disable iff (!hresetn)
        !modem.transceive |=> link_fsm_state == MS_IDLE;
    endproperty
    a_modem_idle: assert property (p_modem_idle) else $error("modem not idle");

    property p_rd_upper;
        @(posedge hclk) disable iff (!hresetn)
        rd_s1 || rd_s2 |=> hrdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");

    property p_tx_wait;
        @(posedge hclk) disable iff (!hresetn)
        link_fsm_state == MS_SEND_WAIT && modem.send_trigger && modem.transceive |=> link_fsm_state == MS_PRE_TX;
    endproperty
    a_tx_wait: assert property (p_tx_wait) else $error("pre-transmit wait missed");

    c_crc_run: cover property (@(posedge hclk) disable iff (!hresetn) core.crc_start ##[1:20] core.crc_finish);
    c_full: cover property (@(posedge hclk) disable iff (!hresetn) fifo_near_full && !fifo_near_empty);
    c_tx: cover property (@(posedge hclk) disable iff (!hresetn) link_fsm_state == MS_TX);
    c_cipher: cover property (@(posedge hclk) disable iff (!hresetn) core.auth_success ##1 cipher_active_r);
    c_ovh_clear: cover property (@(posedge hclk) disable iff (!hresetn) overheat_error ##1 !overheat_error);
endmodule

/* File: tb/host_master.sv */
// host_master: ahb-lite master standing in for host software
// assumes: one slave whose hreadyout is the bus hready, whole-word single transfers
`timescale 1ns/1ns
module host_master (
    input  wire logic        hclk,   // bus clock
    input  wire logic        hready, // bus ready
    input  wire logic [31:0] hrdata, // read data
    output logic             hsel,   // slave select
    output logic [31:0]      haddr,  // byte address
    output logic [1:0]       htrans, // transfer type
    output logic             hwrite, // write when high
    output logic [2:0]       hsize,  // always a word
    output logic [31:0]      hwdata  // write data
);
    logic [31:0] rdata;
    logic        tmo = 1'b0;
    event        got;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // ==========================================
    // bus cycles
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (n >= 40)
            tmo = 1'b1;
    endtask
    // status reads at any time, also during frames; cipher clears by writing zero, overheat error by the overheat clear bit set while below the temp limit
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready();
        rdata = hrdata;
        if (!w)
            -> got;
    endtask
endmodule

/* File: tb/reader_status_regs_tb.sv */
// reader_status_regs_tb: self-checking bench of the status registers
// assumes: host_master on the bus, core and modem inputs driven here
`timescale 1ns/1ns
module reader_status_regs_tb;
    import status_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, link_fsm_state;
    logic [7:0]  irq_src, r;
    logic [5:0]  thr;
    logic        overheat_error, rx_crc_error_flag, filter_hs_mode;
    core_in_t    core;
    modem_in_t   modem;
    logic [31:0] exp_q[$];
    int          n_errors = 0, total_checks = 0, n, c;

    reader_status_regs i_reader_status_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core(core), .irq_src(irq_src),
        .modem(modem), .overheat_error(overheat_error), .rx_crc_error_flag(rx_crc_error_flag),
        .filter_hs_mode(filter_hs_mode), .link_fsm_state(link_fsm_state));
    host_master i_host_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // ==========================================
    // checking and helpers
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read results are compared in order as they come back
    always @(i_host_master.got) begin
        chk(i_host_master.rdata, exp_q.pop_front());
        chk(32'(hresp), 32'h0);
    end
    always @(posedge hclk) begin
        if (i_host_master.tmo) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        i_host_master.xfer(1'b0, idx, 8'h00);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_host_master.xfer(1'b1, idx, d);
    endtask
    task automatic clks(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic pulse_core(input core_in_t m);
        @(posedge hclk);
        core <= core | m;
        @(posedge hclk);
        core <= core & ~m;
    endtask
    task automatic pulse_modem(input modem_in_t m);
        @(posedge hclk);
        modem <= modem | m;
        @(posedge hclk);
        modem <= modem & ~m;
    endtask
    task automatic wait_state(input logic [2:0] s);
        n = 0;
        while (link_fsm_state !== s && n < 50) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(link_fsm_state), 32'(s));
    endtask
    // ==========================================
    // main sequence
    initial begin
        core = '0;
        modem = '0;
        irq_src = 8'h00;
        hresetn = 1'b0;
        void'($urandom(32'hdcd4));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_STATUS1, 8'h21);
        chk(32'(hreadyout), 32'h1);
        rd(IDX_STATUS2, 8'h00);
        rd(IDX_THRESHOLD, 8'h08);
        rd(8'h3f, 8'h00);
        wr(IDX_STATUS1, 8'hff);
        rd(IDX_STATUS1, 8'h21);
        wr(IDX_STATUS2, 8'h7f);
        rd(IDX_STATUS2, 8'h40);
        clks(2);
        chk(32'(filter_hs_mode), 32'h1);
        wr(IDX_STATUS2, 8'h00);
        core.protocol_hs <= 1'b1;
        clks(3);
        chk(32'(filter_hs_mode), 32'h1);
        core.protocol_hs <= 1'b0;
        clks(3);
        chk(32'(filter_hs_mode), 32'h0);
        pulse_core('{crc_start: 1'b1, default: 1'b0});
        rd(IDX_STATUS1, 8'h01);
        core.crc_zero <= 1'b1;
        pulse_core('{crc_finish: 1'b1, default: 1'b0});
        rd(IDX_STATUS1, 8'h61);
        core.crc_zero <= 1'b0;
        pulse_core('{crc_start: 1'b1, default: 1'b0});
        pulse_core('{crc_finish: 1'b1, default: 1'b0});
        rd(IDX_STATUS1, 8'h21);
        r = 8'($urandom) | 8'h01;
        irq_src <= r;
        wr(IDX_IRQ_EN, r);
        rd(IDX_STATUS1, 8'h31);
        wr(IDX_IRQ_EN, ~r);
        rd(IDX_STATUS1, 8'h21);
        core.timer_run <= 1'b1;
        rd(IDX_STATUS1, 8'h29);
        core.timer_run <= 1'b0;
        rd(IDX_STATUS1, 8'h21);
        thr = 6'($urandom_range(1, 16));
        wr(IDX_THRESHOLD, {2'b11, thr});
        rd(IDX_THRESHOLD, {2'b00, thr});
        for (int i = 0; i <= 130; i++) begin
            c = (i <= 64) ? i : ((i <= 129) ? 129 - i : 0);
            rd(IDX_STATUS1, {6'h08, 1'((64 - c) <= int'(thr)), 1'(c <= int'(thr))});
            if (i <= 64)
                wr(IDX_FIFO_DATA, 8'($urandom));
            else if (i < 130)
                rd(IDX_FIFO_DATA, 8'h00);
        end
        pulse_core('{auth_success: 1'b1, default: 1'b0});
        pulse_core('{cmd_start: 1'b1, default: 1'b0});
        rd(IDX_STATUS2, 8'h08);
        wr(IDX_STATUS2, 8'h08);
        rd(IDX_STATUS2, 8'h08);
        wr(IDX_STATUS2, 8'h00);
        rd(IDX_STATUS2, 8'h00);
        pulse_core('{crc_fail: 1'b1, overheat_detect: 1'b1, default: 1'b0});
        clks(2);
        chk(32'(rx_crc_error_flag), 32'h1);
        pulse_core('{cmd_start: 1'b1, default: 1'b0});
        clks(2);
        chk(32'({overheat_error, rx_crc_error_flag}), 32'h2);
        wr(IDX_STATUS2, 8'h80);
        clks(3);
        chk(32'(overheat_error), 32'h1);
        core.temp_below_limit <= 1'b1;
        clks(3);
        chk(32'(overheat_error), 32'h0);
        rd(IDX_STATUS2, 8'h80);
        wr(IDX_STATUS2, 8'h00);
        modem.wait_for_field <= 1'b1;
        modem.tx_delay <= 8'h03;
        modem.rx_delay <= 8'h02;
        modem.transceive <= 1'b1;
        wait_state(3'b001);
        pulse_modem('{send_trigger: 1'b1, default: 1'b0});
        wait_state(3'b010);
        clks(10);
        rd(IDX_STATUS2, 8'h02);
        modem.field_present <= 1'b1;
        wait_state(3'b011);
        pulse_modem('{tx_done: 1'b1, default: 1'b0});
        wait_state(3'b100);
        wait_state(3'b101);
        chk(32'(n >= 2), 32'h1);
        pulse_modem('{rx_sof: 1'b1, default: 1'b0});
        wait_state(3'b110);
        rd(IDX_STATUS2, 8'h06);
        pulse_modem('{rx_done: 1'b1, default: 1'b0});
        wait_state(3'b001);
        modem.transceive <= 1'b0;
        wait_state(3'b000);
        clks(2);
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge hclk);
        n_errors++;
        print_verdict();
    end
endmodule
